// file: jts_pkg.sv
// test access port package: constants, state type and pin bundles
// assumes one system clock that oversamples the test clock pins
//
// Function
// - sample tdi and tms on rising tck
// - change tdo only on falling tck
// - advance tap state on rising tck
// - capture-ir loads 10000001 into shifter
// - enable tdo on falling edge in shift
// - shift only in shift-ir or shift-dr
// - one instruction bit per rising edge
// - captured pattern leaves on tdo serially
// - final bit shifts entering exit1-ir
// - tdo high impedance after exit1 falling
// - all ones selects the bypass instruction
// - update-ir loads instruction on falling edge
// - bypass captures zero leaving capture-dr
// - bypass path delays data one bit
// - update-dr loads update stage falling edge
// - bypass keeps flip-flops in normal mode
package jts_pkg;

  // ==========================================================
  // instruction register
  localparam int unsigned IR_WIDTH   = 8;
  localparam logic [7:0]  IR_CAPTURE = 8'h81;       // fixed capture pattern
  localparam logic [7:0]  IR_BYPASS  = 8'hff;       // all ones selects bypass
  localparam logic [7:0]  IR_DEFAULT = IR_BYPASS;   // loaded in reset state

  // ==========================================================
  // pin sampling
  localparam int unsigned SYNC_STAGES = 3;          // flops on each pin input

  // ==========================================================
  // tap controller states
  typedef enum logic [3:0] {
    TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PAUDR, EX2DR, UPDDR,
    SELIR, CAPIR, SHIR, EX1IR, PAUIR, EX2IR, UPDIR
  } jts_state_type;

  // ==========================================================
  // pin bundles
  typedef struct packed {
    logic tck;     // test clock from the controller
    logic tms;     // mode select
    logic tdi;     // serial data in
  } jts_pins_type;

  typedef struct packed {
    logic data;    // serial data out level
    logic oe;      // high while the device drives the pin
  } jts_tdo_type;

endpackage

// file: jts_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output follows once stages two and three agree
`timescale 1ns/1ps
module jts_sync
  import jts_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // pins and filtered levels
  input  wire jts_pkg::jts_pins_type pinIn,
  output jts_pkg::jts_pins_type   pinLvl
);
  import jts_pkg::*;

  // ==========================================================
  // synchroniser chain
  jts_pins_type stage1_r;   // read only by stage2_r
  jts_pins_type stage2_r;
  jts_pins_type stage3_r;
  jts_pins_type level_r;    // filtered level

  // chain shift; stage one metastability is kept away from logic
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // per-bit agreement filter; a one-sample glitch never reaches the tap
  always_ff @(posedge clk) begin
    if (srst) begin
      level_r <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (stage2_r[i] == stage3_r[i]) begin
          level_r[i] <= stage3_r[i];
        end
      end
    end
  end

  assign pinLvl = level_r;

endmodule

// file: jts_tap.sv
// test access port: tap controller, instruction register, bypass register, tdo drive
// assumes tck is a slow pin oversampled by clk; tms and tdi settle a half tck before rise
`timescale 1ns/1ps
module jts_tap
  import jts_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // test pins from the controller
  input  wire jts_pkg::jts_pins_type pins,
  // test data out, split into level and enable
  output jts_pkg::jts_tdo_type       tdoPin,
  // status toward the flip-flop core
  output jts_pkg::jts_state_type     tapState,
  output logic                       normalMode,
  output logic                       drUpdateBit
);
  import jts_pkg::*;

  // all checks in this module run on clk and sleep through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // next state of the sixteen state controller
  function automatic jts_state_type tapNext(input jts_state_type s, input logic tms);
    jts_state_type n;
    n = s;
    case (s)
      TLR:     n = tms ? TLR   : RTI;
      RTI:     n = tms ? SELDR : RTI;
      SELDR:   n = tms ? SELIR : CAPDR;
      CAPDR:   n = tms ? EX1DR : SHDR;
      SHDR:    n = tms ? EX1DR : SHDR;
      EX1DR:   n = tms ? UPDDR : PAUDR;
      PAUDR:   n = tms ? EX2DR : PAUDR;
      EX2DR:   n = tms ? UPDDR : SHDR;
      UPDDR:   n = tms ? SELDR : RTI;
      SELIR:   n = tms ? TLR   : CAPIR;
      CAPIR:   n = tms ? EX1IR : SHIR;
      SHIR:    n = tms ? EX1IR : SHIR;
      EX1IR:   n = tms ? UPDIR : PAUIR;
      PAUIR:   n = tms ? EX2IR : PAUIR;
      EX2IR:   n = tms ? UPDIR : SHIR;
      UPDIR:   n = tms ? SELDR : RTI;
      default: n = TLR;
    endcase
    return n;
  endfunction

  // ==========================================================
  // pin sampling and tck edge detection
  jts_pins_type  pinLvl;       // filtered pin levels
  logic          tckPrev_r;    // filtered tck one clk ago
  logic          tckRise;      // one clk pulse per rising tck
  logic          tckFall;      // one clk pulse per falling tck

  jts_sync u_sync (
    .clk    (clk),
    .srst   (srst),
    .pinIn  (pins),
    .pinLvl (pinLvl)
  );

  // previous tck level; tms and tdi share the same latency so they line up
  always_ff @(posedge clk) begin
    if (srst) begin
      tckPrev_r <= 1'b0;
    end else begin
      tckPrev_r <= pinLvl.tck;
    end
  end

  assign tckRise = pinLvl.tck & ~tckPrev_r;
  assign tckFall = ~pinLvl.tck & tckPrev_r;

  // ==========================================================
  // tap controller state
  jts_state_type state_r;      // current state
  jts_state_type state_nxt;    // state after the coming rising tck

  assign state_nxt = tapNext(state_r, pinLvl.tms);

  // state moves only on a rising tck, by the sampled tms
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= TLR;
    end else if (tckRise) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // instruction register
  logic [7:0] irShift_r;       // serial shifter
  logic [7:0] irActive_r;      // active instruction
  logic       bypassSel;       // bypass instruction in force

  // capture and shift on the rising tck leaving the state
  always_ff @(posedge clk) begin
    if (srst) begin
      irShift_r <= IR_CAPTURE;
    end else if (tckRise) begin
      if (state_r == CAPIR) begin
        irShift_r <= IR_CAPTURE;
      end else if (state_r == SHIR) begin
        // lsb leaves first; the last bit moves on the edge into exit1
        irShift_r <= {pinLvl.tdi, irShift_r[7:1]};
      end
    end
  end

  // reset state wins over any update; update-ir acts on falling tck
  always_ff @(posedge clk) begin
    if (srst) begin
      irActive_r <= IR_DEFAULT;
    end else if (state_r == TLR) begin
      irActive_r <= IR_DEFAULT;
    end else if (tckFall && state_r == UPDIR) begin
      irActive_r <= irShift_r;
    end
  end

  // every opcode other than all ones selects bypass too, since no other
  // data register is built here; only all ones also keeps normal mode
  assign bypassSel  = (irActive_r == IR_BYPASS);
  assign normalMode = bypassSel;

  // ==========================================================
  // bypass register and its update stage
  logic bypass_r;              // single-bit bypass cell
  logic drUpd_r;               // update stage of the selected data register

  // capture zero, then one-bit delay line while shifting
  always_ff @(posedge clk) begin
    if (srst) begin
      bypass_r <= 1'b0;
    end else if (tckRise) begin
      if (state_r == CAPDR) begin
        bypass_r <= 1'b0;
      end else if (state_r == SHDR) begin
        bypass_r <= pinLvl.tdi;
      end
    end
  end

  // update stage loads on falling tck in update-dr
  always_ff @(posedge clk) begin
    if (srst) begin
      drUpd_r <= 1'b0;
    end else if (tckFall && state_r == UPDDR) begin
      drUpd_r <= bypass_r;
    end
  end

  assign drUpdateBit = drUpd_r;

  // ==========================================================
  // tdo drive, changed only on falling tck
  logic tdoData_r;             // tdo level
  logic tdoOe_r;               // tdo enable

  // enable in shift states, float everywhere else incl. exit1 and reset
  always_ff @(posedge clk) begin
    if (srst) begin
      tdoData_r <= 1'b0;
      tdoOe_r   <= 1'b0;
    end else if (tckFall) begin
      case (state_r)
        SHIR: begin
          tdoData_r <= irShift_r[0];
          tdoOe_r   <= 1'b1;
        end
        SHDR: begin
          tdoData_r <= bypass_r;
          tdoOe_r   <= 1'b1;
        end
        default: begin
          tdoOe_r   <= 1'b0;
        end
      endcase
    end
  end

  // one driver for the whole bundle keeps the output a single writer
  assign tdoPin      = '{data: tdoData_r, oe: tdoOe_r};
  assign tapState    = state_r;

  // ==========================================================
  // checks

  property p_tdoOnFall;
    !$stable(tdoOe_r) || !$stable(tdoData_r) |-> $past(tckFall);
  endproperty
  a_tdoOnFall: assert property (p_tdoOnFall) else $error("tdo moved without falling tck");

  property p_stateOnRise;
    !$stable(state_r) |-> $past(tckRise);
  endproperty
  a_stateOnRise: assert property (p_stateOnRise) else $error("state moved without rising tck");

  property p_captureIr;
    tckRise && state_r == CAPIR |=> irShift_r == IR_CAPTURE && state_r != CAPIR;
  endproperty
  a_captureIr: assert property (p_captureIr) else $error("capture pattern not loaded");

  property p_shiftIr;
    tckRise && state_r == SHIR |=> irShift_r == {$past(pinLvl.tdi), $past(irShift_r[7:1])};
  endproperty
  a_shiftIr: assert property (p_shiftIr) else $error("instruction shift wrong");

  property p_noShiftIdle;
    !(state_r inside {CAPIR, SHIR}) |=> $stable(irShift_r);
  endproperty
  a_noShiftIdle: assert property (p_noShiftIdle) else $error("shifter moved outside shift");

  property p_oeShift;
    tckFall && state_r inside {SHIR, SHDR} |=> tdoOe_r;
  endproperty
  a_oeShift: assert property (p_oeShift) else $error("tdo not enabled in shift");

  property p_exitFloat;
    tckFall && state_r inside {EX1IR, EX1DR} |=> !tdoOe_r;
  endproperty
  a_exitFloat: assert property (p_exitFloat) else $error("tdo still driven in exit1");

  property p_updateIr;
    tckFall && state_r == UPDIR |=> irActive_r == $past(irShift_r);
  endproperty
  a_updateIr: assert property (p_updateIr) else $error("instruction not updated");

  property p_bypassCap;
    tckRise && state_r == CAPDR |=> !bypass_r;
  endproperty
  a_bypassCap: assert property (p_bypassCap) else $error("bypass did not capture zero");

  property p_tlrDefault;
    state_r == TLR |=> irActive_r == IR_DEFAULT && !tdoOe_r;
  endproperty
  a_tlrDefault: assert property (p_tlrDefault) else $error("reset state did not restore default");

endmodule

// file: jts_ctrl_model.sv
// controller model: makes tck, drives tms and tdi, samples tdo in the high phase
// assumes the device answers each tck edge within about 55 ns
`timescale 1ns/1ps
module jts_ctrl_model (
  // pins toward the device
  output jts_pkg::jts_pins_type pins,
  // pins from the device
  input  wire jts_pkg::jts_tdo_type tdo
);
  import jts_pkg::*;
  // ==========================================================
  // pacing
  real gapNs = 0.0;  // extra high time per bit; nonzero plays a slow controller

  // tck parked low with pins quiet until the first frame
  initial pins = '0;

  // ==========================================================
  // one bit: tms and tdi change on the fall, so they settle a half period
  // before the rise; tdo is read well after the device answered the fall
  task automatic bitCycle(input logic m, input logic d, output logic q, output logic e);
    #(4.5 + gapNs);
    pins.tck <= 1'b0;
    pins.tms <= m;
    pins.tdi <= d;
    #62.5;
    pins.tck <= 1'b1;
    #31;
    // a floating tdo reads as the inverse, so a missing enable shows up as a bad bit
    q = tdo.oe ? tdo.data : ~tdo.data;
    e = tdo.oe;
    #27;
  endtask

  // tck stands still low between frames
  task automatic park();
    pins.tck <= 1'b0;
    #200;
  endtask
endmodule

// file: tb_top.sv
// testbench: instruction and bypass scans, random tms walk, reset in mid-shift
// assumes jts_ctrl_model drives the pins at 125 ns per tck, 325 ns on the slow passes
`timescale 1ns/1ps
module tb_top;
  import jts_pkg::*;
  // ==========================================================
  // signals
  logic          clk;                  // system clock
  logic          srst;                 // synchronous reset
  jts_pins_type  pins;                 // pins from the model
  jts_tdo_type   tdoPin;               // tdo level and enable
  jts_state_type tapState;             // design state
  logic          normalMode;           // bypass instruction active
  logic          drUpdateBit;          // bypass update stage
  jts_state_type expSt;                // reference state
  int            err_count = 0;        // mismatches
  int            compares = 0;         // comparisons made
  logic [31:0]   seed = 32'heeac8854;  // fixed seed keeps runs repeatable
  logic          q;                    // last sampled tdo level
  logic [7:0]    op;                   // opcode shifted in
  logic [7:0]    dat;                  // bypass data
  int            n;                    // bypass bit count
  logic [9:0]    tmsWalk = 10'b0001011111;  // five ones to reset, then into shift-dr

  jts_tap jts_tap_i (.clk(clk), .srst(srst), .pins(pins), .tdoPin(tdoPin), .tapState(tapState),
                     .normalMode(normalMode), .drUpdateBit(drUpdateBit));
  jts_ctrl_model jts_ctrl_model_i (.pins(pins), .tdo(tdoPin));

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs about 75 us; a hang is cut at 200 us
  initial begin
    #200us;
    err_count++;
    $display("FAIL t=%0t watchdog expired", $time);
    conclude();
  end

  // ==========================================================
  // reference helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // sixteen-state successor, default arm is update-ir
  function automatic jts_state_type nxt(input jts_state_type s, input logic m);
    case (s)
      TLR:     return m ? TLR : RTI;
      RTI:     return m ? SELDR : RTI;
      SELDR:   return m ? SELIR : CAPDR;
      CAPDR:   return m ? EX1DR : SHDR;
      SHDR:    return m ? EX1DR : SHDR;
      EX1DR:   return m ? UPDDR : PAUDR;
      PAUDR:   return m ? EX2DR : PAUDR;
      EX2DR:   return m ? UPDDR : SHDR;
      UPDDR:   return m ? SELDR : RTI;
      SELIR:   return m ? TLR : CAPIR;
      CAPIR:   return m ? EX1IR : SHIR;
      SHIR:    return m ? EX1IR : SHIR;
      EX1IR:   return m ? UPDIR : PAUIR;
      PAUIR:   return m ? EX2IR : PAUIR;
      EX2IR:   return m ? UPDIR : SHIR;
      default: return m ? SELDR : RTI;
    endcase
  endfunction

  task automatic cmpBit(input logic g, input logic x);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("FAIL t=%0t bit got %b exp %b", $time, g, x);
    end
  endtask

  task automatic cmpSt(input jts_state_type g, input jts_state_type x);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("FAIL t=%0t state got %0d exp %0d", $time, g, x);
    end
  endtask

  // one tck bit; tdo may be enabled only while the bit is in a shift state
  task automatic step(input logic m, input logic d);
    logic e;
    jts_ctrl_model_i.bitCycle(m, d, q, e);
    // look between clk edges so a register launched on this step is settled
    @(negedge clk);
    cmpBit(e, expSt inside {SHIR, SHDR});
    expSt = nxt(expSt, m);
    cmpSt(tapState, expSt);
  endtask

  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    expSt = TLR;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    cmpSt(tapState, TLR);
    cmpBit(tdoPin.oe, 1'b0);
    cmpBit(normalMode, 1'b1);
    // bypass, all zeros, then random opcodes; odd passes use a slow controller
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      op = (k == 0) ? IR_BYPASS : (k == 1) ? 8'h00 : seed[7:0];
      dat = (k == 0) ? 8'h05 : seed[15:8];
      n = (k == 0) ? 3 : 1 + seed[18:16];
      jts_ctrl_model_i.gapNs = (k % 2) ? 200.0 : 0.0;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < 8; i++) begin
        step(i == 7, op[i]);
        cmpBit(q, IR_CAPTURE[i]);
      end
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      cmpBit(normalMode, op == IR_BYPASS);
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
        step(i == n - 1, dat[i]);
        cmpBit(q, (i == 0) ? 1'b0 : dat[i - 1]);
      end
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      cmpBit(drUpdateBit, dat[n - 1]);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
      cmpBit(normalMode, 1'b1);
    end
    // random walk reaches pause and exit2 states
    jts_ctrl_model_i.gapNs = 0.0;
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      step(seed[0], seed[1]);
    end
    // five ones reach reset from anywhere, then into shift-dr
    for (int i = 0; i < 10; i++) begin
      step(tmsWalk[i], 1'b1);
    end
    // reset while shifting with tdo enabled
    jts_ctrl_model_i.park();
    cmpBit(tdoPin.oe, 1'b1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    expSt = TLR;
    cmpSt(tapState, TLR);
    cmpBit(tdoPin.oe, 1'b0);
    conclude();
  end
endmodule
